// ==== logic/bsc_params.svh ====
// constants for the backplane system controller configuration block
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH
// i/o addresses of the block; all but the user register address are decoded here
`define BSC_USER_REG_ADDR 16'h025c
`define BSC_VIDEO_ENABLE_ADDR 16'h03c3
`define BSC_SERIAL_LO 16'h03f8
`define BSC_SERIAL_HI 16'h03ff
`define BSC_VIDEO_LO 16'h03b0
`define BSC_VIDEO_HI 16'h03df
// user register field positions
`define BSC_USER_BIT_A 4
`define BSC_USER_BIT_B 5
// default value of the bus clock divider half period, in sys_clk cycles
`define BSC_CLK_HALF_DIV 2
`endif

// ==== logic/bsc_pkg.sv ====
// types shared by the backplane system controller configuration block
`default_nettype none
package bsc_pkg;
   // arbiter states, gray coded between idle and grant zero only
   typedef enum logic [1:0]
   {
      BSC_IDLE = 2'b00,
      BSC_GRANT0 = 2'b01,
      BSC_GRANT1 = 2'b11
   } bsc_arb_t;
endpackage : bsc_pkg
`default_nettype wire

// ==== logic/bsc_clkgen.sv ====
// divider that makes the backplane system clock level
`timescale 1ns/1ps
`default_nettype none
`include "bsc_params.svh"
module bsc_clkgen #(
   parameter int HALF_DIV = `BSC_CLK_HALF_DIV
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // clock out
   output logic clk_level
);
   logic [7:0] cnt; // half period counter
   // -------------------------------------------------------------
   // toggle the level every half period
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt <= 8'h00;
         clk_level <= 1'b0;
      end
      else if (cnt == 8'(HALF_DIV - 1))
      begin
         cnt <= 8'h00;
         clk_level <= ~clk_level;
      end
      else
      begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule : bsc_clkgen
`default_nettype wire

// ==== logic/bsc_ctrl.sv ====
// backplane system controller, arbiter and address redirect logic
// Function
// - jumper A drives system reset during cpu reset
// - jumper B: no drive, reset from backplane
// - clock jumper fitted drives system clock
// - interface never uses the backplane clock
// - arbiter jumper fitted: default master with arbiter
// - potential master requests on level by jumper
// - level jumper ignored when default master
// - request zero beats simultaneous request one
// - serial jumper selects onboard or backplane port
// - user jumpers read fitted zero, omitted one
// - video jumper omitted serves video onboard
// - address 3c3h always stays onboard
// - grants answer on matching acknowledge lines
// - default master owns bus when idle
`timescale 1ns/1ps
`default_nettype none
`include "bsc_params.svh"
module bsc_ctrl #(
   parameter int CLK_HALF_DIV = `BSC_CLK_HALF_DIV
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // jumpers, high when fitted
   input wire logic reset_source_jumper,
   input wire logic clock_drive_jumper,
   input wire logic arbiter_select_jumper,
   input wire logic request_level_jumper,
   input wire logic serial_redirect_jumper,
   input wire logic user_jumper_a,
   input wire logic user_jumper_b,
   input wire logic video_redirect_jumper,
   // cpu side
   input wire logic cpu_in_reset,
   input wire logic cpu_bus_want,
   input wire logic [15:0] io_addr,
   input wire logic io_strobe,
   // backplane reset pin
   input wire logic sysrst_n_in,
   output logic sysrst_n_out,
   output logic sysrst_n_oe,
   output logic board_reset,
   // backplane clock pin
   output logic sysclk_out,
   output logic sysclk_oe,
   // arbitration lines
   input wire logic busrq0_n_in,
   input wire logic busrq1_n_in,
   output logic busrq0_n_out,
   output logic busrq0_n_oe,
   output logic busrq1_n_out,
   output logic busrq1_n_oe,
   output logic busak0_n,
   output logic busak1_n,
   output logic busak_oe,
   input wire logic busak0_n_in,
   input wire logic busak1_n_in,
   output logic own_bus,
   // decode results
   output logic io_to_backplane,
   output logic io_serial_local,
   output logic io_video_local,
   output logic [7:0] user_reg
);
   // -------------------------------------------------------------
   // decode wires
   // -------------------------------------------------------------
   // only the serial and video ranges can be sent to the backplane from here
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range
   wire logic serial_hit = in_range(io_addr, `BSC_SERIAL_LO, `BSC_SERIAL_HI);
   wire logic video_hit = in_range(io_addr, `BSC_VIDEO_LO, `BSC_VIDEO_HI);
   wire logic video_en_hit = (io_addr == `BSC_VIDEO_ENABLE_ADDR);
   wire logic ser_local = serial_hit && serial_redirect_jumper;
   wire logic vid_local = video_en_hit || (video_hit && !video_redirect_jumper);
   wire logic to_bp = io_strobe && ((serial_hit && !ser_local) || (video_hit && !vid_local));
   wire logic [7:0] next_user;
   // fitted reads zero
   assign next_user = {2'b00, ~user_jumper_b, ~user_jumper_a, 4'h0};
   wire logic default_master = arbiter_select_jumper;
   wire logic rq0 = !busrq0_n_in;
   wire logic rq1 = !busrq1_n_in;
   wire logic hold_rst = reset_source_jumper ? cpu_in_reset : !sysrst_n_in;
   bsc_pkg::bsc_arb_t state;
   bsc_pkg::bsc_arb_t next_state;
   logic clk_level; // divided clock level
   // -------------------------------------------------------------
   // arbiter next state
   // -------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         bsc_pkg::BSC_IDLE:
         begin
            if (rq0)
               next_state = bsc_pkg::BSC_GRANT0;
            else if (rq1)
               next_state = bsc_pkg::BSC_GRANT1;
         end
         bsc_pkg::BSC_GRANT0:
         begin
            if (!rq0)
               next_state = bsc_pkg::BSC_IDLE;
         end
         bsc_pkg::BSC_GRANT1:
         begin
            if (!rq1)
               next_state = bsc_pkg::BSC_IDLE;
         end
         default: next_state = bsc_pkg::BSC_IDLE;
      endcase
      if (!default_master)
         next_state = bsc_pkg::BSC_IDLE;
   end
   // -------------------------------------------------------------
   // clock divider, free of the backplane clock
   // -------------------------------------------------------------
   bsc_clkgen #(.HALF_DIV(CLK_HALF_DIV)) u_clk (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .clk_level(clk_level)
   );
   // -------------------------------------------------------------
   // registered outputs; nothing here samples the backplane clock
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= bsc_pkg::BSC_IDLE;
         sysrst_n_out <= 1'b0;
         sysrst_n_oe <= 1'b0;
         board_reset <= 1'b1;
         sysclk_out <= 1'b0;
         sysclk_oe <= 1'b0;
         busrq0_n_out <= 1'b1;
         busrq0_n_oe <= 1'b0;
         busrq1_n_out <= 1'b1;
         busrq1_n_oe <= 1'b0;
         busak0_n <= 1'b1;
         busak1_n <= 1'b1;
         busak_oe <= 1'b0;
         own_bus <= 1'b0;
         io_to_backplane <= 1'b0;
         io_serial_local <= 1'b0;
         io_video_local <= 1'b0;
         user_reg <= 8'h00;
      end
      else
      begin
         state <= next_state;
         // reset pin drives low only in source mode during cpu reset
         sysrst_n_out <= 1'b0;
         sysrst_n_oe <= reset_source_jumper && cpu_in_reset;
         board_reset <= hold_rst;
         sysclk_out <= clk_level;
         sysclk_oe <= clock_drive_jumper;
         // potential master drives its selected request line
         busrq0_n_out <= 1'b0;
         busrq1_n_out <= 1'b0;
         busrq0_n_oe <= !default_master && cpu_bus_want && request_level_jumper;
         busrq1_n_oe <= !default_master && cpu_bus_want && !request_level_jumper;
         // grants follow next_state, so they show one cycle after a request
         busak0_n <= !(next_state == bsc_pkg::BSC_GRANT0);
         busak1_n <= !(next_state == bsc_pkg::BSC_GRANT1);
         busak_oe <= default_master;
         if (default_master)
            own_bus <= (next_state == bsc_pkg::BSC_IDLE);
         else if (request_level_jumper)
            own_bus <= cpu_bus_want && !busak0_n_in;
         else
            own_bus <= cpu_bus_want && !busak1_n_in;
         io_to_backplane <= to_bp;
         io_serial_local <= io_strobe && ser_local;
         io_video_local <= io_strobe && vid_local;
         user_reg <= next_user;
      end
   end
   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   // antecedents also need nrst sampled high: an attempt that starts on the
   // releasing edge would otherwise judge outputs still holding reset values
   a_one_grant: assert property (@(posedge sys_clk) disable iff (!nrst)
      !(!busak0_n && !busak1_n)) else $error("two grants at once");
   a_rq0_first: assert property (@(posedge sys_clk) disable iff (!nrst)
      (nrst && default_master && state == bsc_pkg::BSC_IDLE && rq0 && rq1) |=> !busak0_n)
      else $error("request zero lost priority");
   a_grant_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      (nrst && default_master && state == bsc_pkg::BSC_GRANT1 && rq1 && $past(default_master))
      |=> !busak1_n) else $error("grant dropped early");
   a_idle_owns: assert property (@(posedge sys_clk) disable iff (!nrst)
      (nrst && default_master && !rq0 && !rq1 && state == bsc_pkg::BSC_IDLE) |=> own_bus)
      else $error("default master not owner");
   a_rst_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
      (nrst && reset_source_jumper && cpu_in_reset) |=> sysrst_n_oe && !sysrst_n_out)
      else $error("reset not driven");
   a_rst_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
      (nrst && !reset_source_jumper) |=> !sysrst_n_oe && (board_reset == !$past(sysrst_n_in)))
      else $error("reset follow wrong");
   a_clk_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
      nrst |=> sysclk_oe == $past(clock_drive_jumper)) else $error("clock enable wrong");
   a_req_level: assert property (@(posedge sys_clk) disable iff (!nrst)
      (nrst && default_master) |=> !busrq0_n_oe && !busrq1_n_oe)
      else $error("request while default");
   a_vid_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
      (nrst && io_strobe && video_en_hit) |=> io_video_local && !io_to_backplane)
      else $error("3c3h left board");
   a_user_bits: assert property (@(posedge sys_clk) disable iff (!nrst)
      nrst |=> (user_reg[`BSC_USER_BIT_A] == !$past(user_jumper_a))
      && (user_reg[`BSC_USER_BIT_B] == !$past(user_jumper_b)))
      else $error("user bit wrong");
endmodule : bsc_ctrl
`default_nettype wire

// ==== test/bsc_far_side.sv ====
// far side of the backplane: other masters, pull-ups and external arbiter
`timescale 1ns/1ps
`default_nettype none
module bsc_far_side (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // scenario controls from the bench
   input wire logic want0,
   input wire logic want1,
   input wire logic hold_rst,
   // device pull-down enables
   input wire logic rq0_oe,
   input wire logic rq1_oe,
   input wire logic rst_oe,
   // device pin levels while enabled
   input wire logic rq0_out,
   input wire logic rq1_out,
   input wire logic rst_out,
   // backplane i/o as a video board sees it
   input wire logic bp_strobe,
   input wire logic [15:0] bp_addr,
   // resolved lines and external grants
   output logic rq0_n,
   output logic rq1_n,
   output logic rst_n,
   output logic ak0_n,
   output logic ak1_n,
   // video board saw 3c3h on the backplane
   output logic saw_3c3
);
   // wired lines with pull-ups, low while any party pulls a low level
   assign rq0_n = ~(want0 | (rq0_oe & ~rq0_out));
   assign rq1_n = ~(want1 | (rq1_oe & ~rq1_out));
   assign rst_n = ~(hold_rst | (rst_oe & ~rst_out));
   // backplane video board: enable register at 46e8h, never 3c3h
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         saw_3c3 <= 1'b0;
      else if (bp_strobe && bp_addr == 16'h03c3)
         saw_3c3 <= 1'b1;
   end
   // external arbiter for potential mode, request zero first
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ak0_n <= 1'b1;
         ak1_n <= 1'b1;
      end
      else
      begin
         ak0_n <= rq0_n;
         ak1_n <= rq1_n | ~rq0_n;
      end
   end
endmodule : bsc_far_side
`default_nettype wire

// ==== test/test_backplane_system_controller_config.sv ====
// self-checking bench for the backplane controller block
`timescale 1ns/1ps
`default_nettype none
module test_backplane_system_controller_config;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic sys_clk = 1'b0, nrst = 1'b0, cpu_rst = 1'b0, want = 1'b0, strobe = 1'b0;
   logic w0 = 1'b0, w1 = 1'b0, hold = 1'b0;
   logic [7:0] j = 8'h00; // jumpers, high when fitted
   logic [15:0] addr = 16'h0000;
   logic rst_oe, brd_rst, clk_o, clk_oe, rq0_oe, rq1_oe, ak0, ak1, ak_oe, own;
   logic rq0_n, rq1_n, rst_n, xak0, xak1, bp, ser, vid;
   logic [7:0] ureg;
   logic rst_o, rq0_o, rq1_o, vid_bad; // pin levels and far side flag
   int n_mismatch = 0, compares = 0;
   always #12.5 sys_clk = ~sys_clk;
   bsc_ctrl #(.CLK_HALF_DIV(2)) bsc_ctrl_i (.sys_clk(sys_clk), .nrst(nrst),
      .reset_source_jumper(j[0]), .clock_drive_jumper(j[1]), .arbiter_select_jumper(j[2]),
      .request_level_jumper(j[3]), .serial_redirect_jumper(j[4]), .user_jumper_a(j[5]),
      .user_jumper_b(j[6]), .video_redirect_jumper(j[7]), .cpu_in_reset(cpu_rst),
      .cpu_bus_want(want), .io_addr(addr), .io_strobe(strobe), .sysrst_n_in(rst_n),
      .sysrst_n_out(rst_o), .sysrst_n_oe(rst_oe), .board_reset(brd_rst), .sysclk_out(clk_o),
      .sysclk_oe(clk_oe), .busrq0_n_in(rq0_n), .busrq1_n_in(rq1_n), .busrq0_n_out(rq0_o),
      .busrq0_n_oe(rq0_oe), .busrq1_n_out(rq1_o), .busrq1_n_oe(rq1_oe), .busak0_n(ak0),
      .busak1_n(ak1), .busak_oe(ak_oe), .busak0_n_in(xak0), .busak1_n_in(xak1),
      .own_bus(own), .io_to_backplane(bp), .io_serial_local(ser), .io_video_local(vid),
      .user_reg(ureg));
   bsc_far_side bsc_far_side_i (.sys_clk(sys_clk), .nrst(nrst), .want0(w0), .want1(w1),
      .hold_rst(hold), .rq0_oe(rq0_oe), .rq1_oe(rq1_oe), .rst_oe(rst_oe), .rq0_n(rq0_n),
      .rq0_out(rq0_o), .rq1_out(rq1_o), .rst_out(rst_o), .bp_strobe(bp), .bp_addr(addr),
      .rq1_n(rq1_n), .rst_n(rst_n), .ak0_n(xak0), .ak1_n(xak1), .saw_3c3(vid_bad));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task edge_; @(posedge sys_clk); endtask : edge_
   task look; @(posedge sys_clk); #1; endtask : look
   task tally_and_finish;
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // bounded wait for a low grant or a high ownership flag
   task automatic wait_for(input int which);
      int i;
      #1;
      for (i = 0; i < 8 && (which ? own !== 1'b1 : ak1 !== 1'b0); i++) look;
      if (i == 8)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, i, 8);
         tally_and_finish;
      end
   endtask : wait_for
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      edge_; j[0] <= 1'b1; cpu_rst <= 1'b1; look;
      chk(rst_oe, 1'b1);
      chk({rst_o, rq0_o, rq1_o}, 8'h00);
      edge_; cpu_rst <= 1'b0; look;
      chk(rst_oe, 1'b0);
      edge_; j[0] <= 1'b0; cpu_rst <= 1'b1; hold <= 1'b1; look; look;
      chk({rst_oe, brd_rst}, 8'h01);
      edge_; cpu_rst <= 1'b0; hold <= 1'b0; look; look;
      chk(brd_rst, 1'b0);
   endtask : t_reset
   task automatic t_clock;
      logic s;
      edge_; j[1] <= 1'b1; look;
      s = clk_o;
      chk(clk_oe, 1'b1);
      look; look;
      chk(clk_o, !s);
      edge_; j[1] <= 1'b0; look;
      chk(clk_oe, 1'b0);
   endtask : t_clock
   task t_arb_default;
      edge_; j[2] <= 1'b1; j[3] <= 1'b1; want <= 1'b1; look; look;
      chk({own, ak_oe, rq0_oe, rq1_oe}, 8'h0c);
      edge_; w0 <= 1'b1; w1 <= 1'b1; look; look;
      chk({ak0, ak1, own}, 8'h02);
      edge_; w0 <= 1'b0; wait_for(0);
      chk(ak0, 1'b1);
      edge_; w0 <= 1'b1; look; look;
      chk({ak0, ak1}, 8'h02);
      edge_; w0 <= 1'b0; w1 <= 1'b0; wait_for(1);
      chk({ak0, ak1}, 8'h03);
      edge_; want <= 1'b0;
   endtask : t_arb_default
   task t_arb_potential;
      edge_; j[2] <= 1'b0; j[3] <= 1'b1; want <= 1'b1; look; look;
      chk({ak_oe, rq0_oe, rq1_oe}, 8'h02);
      wait_for(1);
      edge_; want <= 1'b0; look;
      edge_; j[3] <= 1'b0; want <= 1'b1; look; look;
      chk({rq0_oe, rq1_oe}, 8'h01);
      wait_for(1);
      edge_; want <= 1'b0; look;
   endtask : t_arb_potential
   task automatic probe(input logic [15:0] a, input logic [2:0] exp);
      edge_; addr <= a; strobe <= 1'b1;
      edge_; strobe <= 1'b0;
      #1;
      chk({bp, ser, vid}, {5'h00, exp});
   endtask : probe
   task t_decode;
      edge_; j[4] <= 1'b1; j[7] <= 1'b0; look;
      probe(16'h03f8, 3'b010);
      probe(16'h03b0, 3'b001);
      edge_; j[4] <= 1'b0; j[7] <= 1'b1; look;
      probe(16'h03ff, 3'b100);
      probe(16'h03df, 3'b100);
      probe(16'h03c3, 3'b001);
      look;
      chk(vid_bad, 1'b0);
   endtask : t_decode
   task t_user;
      edge_; j[5] <= 1'b1; j[6] <= 1'b0; look; look;
      chk(ureg, 8'h20);
      edge_; j[5] <= 1'b0; j[6] <= 1'b1; look; look;
      chk(ureg, 8'h10);
   endtask : t_user
   // main sequence after reset
   initial
   begin
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset; t_clock; t_arb_default; t_arb_potential; t_decode; t_user;
      tally_and_finish;
   end
endmodule : test_backplane_system_controller_config
`default_nettype wire
